/* File: logic/iepr_pkg.sv */
// Constants shared by the interrupt enable and priority register block.
`default_nettype none
package iepr_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_ENABLE   = 8'ha8; // Enable register address.
   localparam logic [7:0] ADDR_PRIORITY = 8'hb8; // Priority register address.
   localparam logic [7:0] PAGE_PRIORITY = 8'h00; // Only page for priority.
   localparam logic [7:0] ENABLE_RESET  = 8'h00; // Enable reset value.
   localparam logic [7:0] PRIO_RESET    = 8'h80; // Priority reset value.
   localparam logic [7:0] PRIO_FIXED    = 8'h80; // Bits that always read one.
   localparam logic [7:0] BYTE_ZERO     = 8'h00; // Answer to unmapped reads.
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int GLOBAL_BIT = 7; // Global enable position.
   localparam int NUM_SRC    = 7; // Sources at bit positions 6 down to 0.
   localparam int SRC_EXT0   = 0; // First external input.
   localparam int SRC_TMR0   = 1; // Timer 0 overflow.
   localparam int SRC_EXT1   = 2; // Second external input.
   localparam int SRC_TMR1   = 3; // Timer 1 overflow.
   localparam int SRC_UART   = 4; // Serial port.
   localparam int SRC_TMR2   = 5; // Timer 2 overflows.
   localparam int SRC_SPI0   = 6; // First SPI unit.
   // ---------------------------------------------------------------
   // Service nesting states
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      SVC_IDLE = 4'b0001, // No routine running.
      SVC_LOW  = 4'b0010, // Low level routine running.
      SVC_HIGH = 4'b0100, // High level routine running alone.
      SVC_NEST = 4'b1000  // High level routine preempting a low one.
   } iepr_svc_t;
endpackage : iepr_pkg
`default_nettype wire

/* File: logic/iepr_arbiter.sv */
// Combinational two-level fixed-order picker for pending requests.
`timescale 1ns/10ps
`default_nettype none
module iepr_arbiter (
   input  wire logic [6:0] i_req,        // Gated requests.
   input  wire logic [6:0] i_prio,       // Level of each source.
   input  wire logic       i_allow_low,  // Low level may be taken.
   input  wire logic       i_allow_high, // High level may be taken.
   output logic            o_valid,      // A request is chosen.
   output logic [2:0]      o_idx,        // Chosen source position.
   output logic            o_high        // Chosen request is high level.
);
   // ---------------------------------------------------------------
   // Selection
   // ---------------------------------------------------------------
   // High level wins first; within a level the lowest position wins,
   // so the loop walks downward and the last hit is kept.
   always_comb begin
      logic [6:0] hi_v;
      logic [6:0] lo_v;
      hi_v    = i_req & i_prio & {7{i_allow_high}};
      lo_v    = i_req & ~i_prio & {7{i_allow_low}};
      o_valid = 1'b0;
      o_idx   = 3'h0;
      o_high  = 1'b0;
      for (int k = 6; k >= 0; k--) begin
         if (lo_v[k] && !(|hi_v)) begin
            o_valid = 1'b1;
            o_idx   = 3'(k);
         end
      end
      for (int k = 6; k >= 0; k--) begin
         if (hi_v[k]) begin
            o_valid = 1'b1;
            o_idx   = 3'(k);
            o_high  = 1'b1;
         end
      end
   end
endmodule : iepr_arbiter
`default_nettype wire

/* File: logic/iepr_top.sv */
// Interrupt enable and priority registers with request arbitration.
// Notes on behaviour
// - Global enable bit 7 overrides every mask.
// - With global on, each mask decides alone.
// - Bit 6 gates the first SPI unit.
// - Bit 5 gates Timer 2, either overflow.
// - Bit 4 gates the UART request.
// - Bit 3 gates Timer 1 overflow.
// - Bit 2 gates second external input.
// - Bit 1 gates Timer 0 overflow.
// - Bit 0 gates first external input.
// - Enable at 0xa8, all pages, bit access, zero reset.
// - Priority at 0xb8, page zero only, bit access.
// - Priority bit 7 reads one, ignores writes.
// - Priority bits follow enable order, reset low.
// - High preempts low; high never preempted.
// - Decode every cycle; ties by fixed order.
`timescale 1ns/10ps
`default_nettype none
module iepr_top (
   input  wire logic       i_ref_clk,          // System clock, 10 MHz.
   input  wire logic       i_nrst,             // Asynchronous reset, active low.
   input  wire logic [7:0] i_sfr_addr,         // Register address.
   input  wire logic [7:0] i_sfr_page,         // Current register page.
   input  wire logic       i_sfr_wr,           // Byte write strobe.
   input  wire logic [7:0] i_sfr_wdata,        // Byte write data.
   input  wire logic       i_sfr_bit_wr,       // Single-bit write strobe.
   input  wire logic [2:0] i_sfr_bit_sel,      // Bit position for bit write.
   input  wire logic       i_sfr_bit_val,      // Bit value for bit write.
   input  wire logic       i_sfr_rd,           // Read strobe.
   input  wire logic       i_ext0_pend,        // First external pending flag.
   input  wire logic       i_timer0_overflow_flag,
   input  wire logic       i_ext1_pend,        // Second external pending flag.
   input  wire logic       i_timer1_overflow_flag,
   input  wire logic       i_uart_pend,        // Serial port pending flag.
   input  wire logic       i_timer2_low_overflow_flag,
   input  wire logic       i_timer2_high_overflow_flag,
   input  wire logic       i_spi0_pend,        // First SPI pending flag.
   input  wire logic       i_isr_enter,        // CPU vectors to the offered source.
   input  wire logic       i_isr_return,       // CPU finishes a routine.
   output logic [7:0]      o_sfr_rdata,        // Read data.
   output logic            o_sfr_rd_hit,       // Read hit a mapped register.
   output logic            o_irq_req,          // Request offered to the CPU.
   output logic [2:0]      o_irq_src,          // Offered source position.
   output logic            o_irq_high,         // Offered request is high level.
   output logic [6:0]      o_src_req           // Gated request of each source.
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]        enable_q, enable_d;     // Enable register.
   logic [7:0]        prio_q, prio_d;         // Priority register.
   logic [7:0]        rdata_q, rdata_d;       // Read data register.
   logic              rhit_q, rhit_d;         // Read hit register.
   logic              irq_q, irq_d;           // Offered request.
   logic [2:0]        src_q, src_d;           // Offered source.
   logic              high_q, high_d;         // Offered level.
   logic [6:0]        sreq_q, sreq_d;         // Gated request copy.
   logic [6:0]        prio_seen_q;            // Priority at offer time.
   iepr_pkg::iepr_svc_t svc_q, svc_d;         // Nesting state.
   logic [6:0]        pend;                   // Pending flags by position.
   logic [6:0]        req_vec;                // Gated requests.
   logic              pick_valid;             // Arbiter found a request.
   logic [2:0]        pick_idx;               // Arbiter choice.
   logic              pick_high;              // Arbiter choice level.
   logic              en_hit, pr_hit;         // Address decode.

   // Address decode; the priority register exists on page zero only.
   assign en_hit = (i_sfr_addr == iepr_pkg::ADDR_ENABLE);
   assign pr_hit = (i_sfr_addr == iepr_pkg::ADDR_PRIORITY) &&
                   (i_sfr_page == iepr_pkg::PAGE_PRIORITY);

   // ---------------------------------------------------------------
   // Source requests
   // ---------------------------------------------------------------
   // Pending flags land at the same position as their mask bit.
   always_comb begin
      pend                     = 7'h00;
      pend[iepr_pkg::SRC_EXT0] = i_ext0_pend;
      pend[iepr_pkg::SRC_TMR0] = i_timer0_overflow_flag;
      pend[iepr_pkg::SRC_EXT1] = i_ext1_pend;
      pend[iepr_pkg::SRC_TMR1] = i_timer1_overflow_flag;
      pend[iepr_pkg::SRC_UART] = i_uart_pend;
      pend[iepr_pkg::SRC_TMR2] = i_timer2_low_overflow_flag |
                                 i_timer2_high_overflow_flag;
      pend[iepr_pkg::SRC_SPI0] = i_spi0_pend;
   end

   // Each request is its flag and its mask, all under the global bit.
   genvar g;
   generate
      for (g = 0; g < iepr_pkg::NUM_SRC; g++) begin : g_gate
         assign req_vec[g] = pend[g] & enable_q[g] &
                             enable_q[iepr_pkg::GLOBAL_BIT];
      end
   endgenerate

   // Arbiter: the nesting state decides which levels may be offered.
   iepr_arbiter u_arb (
      .i_req        (req_vec),
      .i_prio       (prio_q[6:0]),
      .i_allow_low  (svc_q == iepr_pkg::SVC_IDLE),
      .i_allow_high ((svc_q == iepr_pkg::SVC_IDLE) ||
                     (svc_q == iepr_pkg::SVC_LOW)),
      .o_valid      (pick_valid),
      .o_idx        (pick_idx),
      .o_high       (pick_high)
   );

   // ---------------------------------------------------------------
   // Register writes and reads
   // ---------------------------------------------------------------
   // A byte write wins over a bit write in the same cycle.
   always_comb begin
      enable_d = enable_q;
      prio_d   = prio_q;
      if (i_sfr_wr && en_hit) begin
         enable_d = i_sfr_wdata;
      end else if (i_sfr_bit_wr && en_hit) begin
         enable_d[i_sfr_bit_sel] = i_sfr_bit_val;
      end
      if (i_sfr_wr && pr_hit) begin
         prio_d = i_sfr_wdata;
      end else if (i_sfr_bit_wr && pr_hit) begin
         prio_d[i_sfr_bit_sel] = i_sfr_bit_val;
      end
      prio_d = prio_d | iepr_pkg::PRIO_FIXED;
      rdata_d = iepr_pkg::BYTE_ZERO;
      rhit_d  = 1'b0;
      if (i_sfr_rd && en_hit) begin
         rdata_d = enable_q;
         rhit_d  = 1'b1;
      end else if (i_sfr_rd && pr_hit) begin
         rdata_d = prio_q | iepr_pkg::PRIO_FIXED;
         rhit_d  = 1'b1;
      end
   end

   // Register state; reset gives zero masks and low priorities.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         enable_q <= iepr_pkg::ENABLE_RESET;
         prio_q   <= iepr_pkg::PRIO_RESET;
         rdata_q  <= iepr_pkg::BYTE_ZERO;
         rhit_q   <= 1'b0;
      end else begin
         enable_q <= enable_d;
         prio_q   <= prio_d;
         rdata_q  <= rdata_d;
         rhit_q   <= rhit_d;
      end
   end

   // ---------------------------------------------------------------
   // Service nesting and offered request
   // ---------------------------------------------------------------
   // Entry takes the level now offered; a return unwinds one level.
   always_comb begin
      svc_d  = svc_q;
      irq_d  = pick_valid;
      src_d  = pick_idx;
      high_d = pick_high;
      sreq_d = req_vec;
      unique case (svc_q)
         iepr_pkg::SVC_IDLE: begin
            if (i_isr_enter && irq_q) begin
               svc_d = high_q ? iepr_pkg::SVC_HIGH : iepr_pkg::SVC_LOW;
            end
         end
         iepr_pkg::SVC_LOW: begin
            if (i_isr_return) begin
               svc_d = iepr_pkg::SVC_IDLE;
            end else if (i_isr_enter && irq_q && high_q) begin
               svc_d = iepr_pkg::SVC_NEST;
            end
         end
         iepr_pkg::SVC_HIGH: begin
            if (i_isr_return) begin
               svc_d = iepr_pkg::SVC_IDLE;
            end
         end
         iepr_pkg::SVC_NEST: begin
            if (i_isr_return) begin
               svc_d = iepr_pkg::SVC_LOW;
            end
         end
         default: begin
            svc_d = iepr_pkg::SVC_IDLE;
         end
      endcase
   end

   // Offer state, refreshed every cycle.
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         svc_q       <= iepr_pkg::SVC_IDLE;
         irq_q       <= 1'b0;
         src_q       <= 3'h0;
         high_q      <= 1'b0;
         sreq_q      <= 7'h00;
         prio_seen_q <= 7'h00;
      end else begin
         svc_q       <= svc_d;
         irq_q       <= irq_d;
         src_q       <= src_d;
         high_q      <= high_d;
         sreq_q      <= sreq_d;
         prio_seen_q <= prio_q[6:0];
      end
   end

   assign o_sfr_rdata  = rdata_q;
   assign o_sfr_rd_hit = rhit_q;
   assign o_irq_req    = irq_q;
   assign o_irq_src    = src_q;
   assign o_irq_high   = high_q;
   assign o_src_req    = sreq_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);

   a_global_off_quiet: assert property (
      !enable_q[iepr_pkg::GLOBAL_BIT] |=> !o_irq_req && (o_src_req == 7'h00))
      else $error("Request offered while global enable off.");
   a_mask_selects_src: assert property (
      o_irq_req |-> o_src_req[o_irq_src])
      else $error("Offered source was not an enabled request.");
   a_src_gate_exact: assert property (
      ##1 o_src_req == ($past(pend) & $past(enable_q[6:0]) &
                        {7{$past(enable_q[7])}}))
      else $error("Gated request mismatch.");
   a_prio_top_one: assert property (
      prio_q[7] and (i_sfr_rd && pr_hit |=> o_sfr_rdata[7]))
      else $error("Priority bit seven not one.");
   a_prio_page_only: assert property (
      i_sfr_rd && i_sfr_addr == iepr_pkg::ADDR_PRIORITY &&
      i_sfr_page != iepr_pkg::PAGE_PRIORITY |=> !o_sfr_rd_hit && o_sfr_rdata == 8'h00)
      else $error("Priority answered off page zero.");
   a_enable_bit_wr: assert property (
      i_sfr_bit_wr && !i_sfr_wr && en_hit |=>
      enable_q[$past(i_sfr_bit_sel)] == $past(i_sfr_bit_val))
      else $error("Enable bit write lost.");
   a_high_not_preempt: assert property (
      (svc_q == iepr_pkg::SVC_HIGH || svc_q == iepr_pkg::SVC_NEST) |=> !o_irq_req)
      else $error("Request offered during high routine.");
   a_low_only_high: assert property (
      svc_q == iepr_pkg::SVC_LOW |=> !o_irq_req || o_irq_high)
      else $error("Low request offered during low routine.");
   a_high_wins_first: assert property (
      o_irq_req && !o_irq_high |-> (o_src_req & prio_seen_q) == 7'h00)
      else $error("Low chosen over a high request.");
   a_fixed_order: assert property (
      o_irq_req |-> (o_src_req & ~(prio_seen_q ^ {7{o_irq_high}}) &
                     7'((8'h01 << o_irq_src) - 8'h01)) == 7'h00)
      else $error("Fixed order not kept within a level.");

   c_nested: cover property (svc_q == iepr_pkg::SVC_LOW ##[1:20] svc_q == iepr_pkg::SVC_NEST);
   c_high_offer: cover property (o_irq_req && o_irq_high);
   c_prio_read: cover property (i_sfr_rd && pr_hit ##1 o_sfr_rd_hit);
endmodule : iepr_top
`default_nettype wire

/* File: verif/iepr_cpu_model.sv */
// Behavioural CPU sequencer that vectors to offered requests and returns on command.
`timescale 1ns/10ps
`default_nettype none
module iepr_cpu_model (
   input  wire logic i_ref_clk, // System clock.
   input  wire logic i_irq_req, // Offer seen from the block.
   input  wire logic i_take,    // Bench lets the CPU vector now.
   input  wire logic i_ret_cmd, // Bench asks for a routine return.
   output logic      o_enter,   // Vector pulse.
   output logic      o_return   // Return pulse.
);
   logic skip_q = 1'b0; // Blocks a second vector while the offer is still stale.
   // ------------------------------------------------------------
   // Pulses change on the falling edge so the block samples them settled.
   // ------------------------------------------------------------
   always @(negedge i_ref_clk) begin
      o_enter  <= i_take && i_irq_req && !skip_q && !i_ret_cmd;
      skip_q   <= i_take && i_irq_req && !skip_q && !i_ret_cmd;
      o_return <= i_ret_cmd;
   end
endmodule : iepr_cpu_model
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the interrupt enable and priority register block.
`timescale 1ns/10ps
`default_nettype none
module tb;
   // ------------------------------------------------------------
   // Stimulus, outputs and model state
   // ------------------------------------------------------------
   logic       clk = 1'b0, nrst = 1'b0;     // Clock and active-low reset.
   logic [7:0] addr = 8'h00, page = 8'h00; // Register address and page.
   logic [7:0] wdata = 8'h00;              // Byte write data.
   logic       wr = 1'b0, bwr = 1'b0;      // Byte and bit write strobes.
   logic       rd = 1'b0, bval = 1'b0;     // Read strobe and bit value.
   logic [2:0] bsel = 3'h0;                // Bit write position.
   logic [7:0] pend = 8'h00;               // Flags; bit 7 is the second Timer 2 flag.
   logic       take = 1'b0, retc = 1'b0;   // CPU commands.
   wire logic  ent, ret, hit, irq, ihigh;  // CPU pulses and block flags.
   wire logic [7:0] rdata;                 // Read data.
   wire logic [2:0] isrc;                  // Offered source.
   wire logic [6:0] sreq;                  // Gated requests.
   logic [7:0] en, pr, nv;                 // Model registers.
   logic       cur_req, cur_high;          // Offer the block shows now.
   logic [31:0] r;                         // Random word.
   int         st, j;                      // Nesting: 0 idle, 1 low, 2 high, 3 nested.
   int         failures = 0, n_tests = 0;
   integer     seed = 32'hbbfb6e5f;
   always #50 clk = ~clk;
   iepr_top dut (.i_ref_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_page(page),
      .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_bit_wr(bwr), .i_sfr_bit_sel(bsel),
      .i_sfr_bit_val(bval), .i_sfr_rd(rd), .i_ext0_pend(pend[0]),
      .i_timer0_overflow_flag(pend[1]), .i_ext1_pend(pend[2]), .i_timer1_overflow_flag(pend[3]),
      .i_uart_pend(pend[4]), .i_timer2_low_overflow_flag(pend[5]),
      .i_timer2_high_overflow_flag(pend[7]), .i_spi0_pend(pend[6]), .i_isr_enter(ent),
      .i_isr_return(ret), .o_sfr_rdata(rdata), .o_sfr_rd_hit(hit), .o_irq_req(irq),
      .o_irq_src(isrc), .o_irq_high(ihigh), .o_src_req(sreq));
   iepr_cpu_model u_cpu (.i_ref_clk(clk), .i_irq_req(irq), .i_take(take), .i_ret_cmd(retc),
      .o_enter(ent), .o_return(ret));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   // Compares one byte-wide result.
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // One clock: predicts from pre-edge state, advances the model, then compares.
   task automatic step();
      logic [6:0] g;
      logic [7:0] ed;
      logic       er, eh, eo;
      logic [2:0] ei;
      #1;
      g = {pend[6], pend[5] | pend[7], pend[4:0]} & en[6:0] & {7{en[7]}};
      er = 1'b0;
      eh = 1'b0;
      ei = 3'h0;
      // Low pass first, then high pass overrides; the lowest position is taken last.
      for (int k = 0; k < 14; k++) begin
         j = (k < 7) ? 6 - k : 13 - k;
         if (g[j] && ((k < 7) ? (st == 0) : (st <= 1 && pr[j]))) begin
            er = 1'b1;
            eh = pr[j];
            ei = j[2:0];
         end
      end
      eo = rd && (addr == iepr_pkg::ADDR_ENABLE ||
         (addr == iepr_pkg::ADDR_PRIORITY && page == iepr_pkg::PAGE_PRIORITY));
      ed = !eo ? 8'h00 : (addr == iepr_pkg::ADDR_ENABLE) ? en : pr;
      @(posedge clk);
      if (ret && st != 0) st = (st == 3) ? 1 : 0;
      else if (ent && cur_req && st == 0) st = cur_high ? 2 : 1;
      else if (ent && cur_req && st == 1 && cur_high) st = 3;
      cur_req = er;
      cur_high = eh;
      if (wr || bwr) begin
         nv = (addr == iepr_pkg::ADDR_ENABLE) ? en : pr;
         nv = wr ? wdata : ((nv & ~(8'h01 << bsel)) | ({7'h00, bval} << bsel));
         if (addr == iepr_pkg::ADDR_ENABLE) en = nv;
         else if (addr == iepr_pkg::ADDR_PRIORITY && page == 8'h00) pr = nv | 8'h80;
      end
      @(negedge clk);
      chk("rdata", ed, rdata);
      chk("rd_hit", {7'h00, eo}, {7'h00, hit});
      chk("src_req", {1'b0, g}, {1'b0, sreq});
      chk("irq_req", {7'h00, er}, {7'h00, irq});
      if (er) chk("irq_pick", {4'h0, eh, ei}, {4'h0, ihigh, isrc});
   endtask : step
   // Drives every bus input once at the falling edge, then runs one clock.
   task automatic cyc(input logic w, b, rr, input logic [7:0] a, pg, d,
                      input logic [2:0] bs, input logic bv);
      wr <= w;
      bwr <= b;
      rd <= rr;
      addr <= a;
      page <= pg;
      wdata <= d;
      bsel <= bs;
      bval <= bv;
      step();
   endtask : cyc
   // Holds reset for six clocks and checks the quiet outputs.
   task automatic do_reset();
      nrst <= 1'b0;
      repeat (6) @(negedge clk);
      chk("rst_out", 8'h00, {hit, irq, ihigh, isrc, 2'b00});
      chk("rst_src", 8'h00, {1'b0, sreq});
      chk("rst_rdata", 8'h00, rdata);
      en = 8'h00;
      pr = 8'h80;
      st = 0;
      cur_req = 1'b0;
      cur_high = 1'b0;
      nrst <= 1'b1;
   endtask : do_reset
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      #(2000 * 100);
      failures++;
      report_and_stop();
   end
   initial begin
      do_reset();
      // Map, refused pages, fixed bit, same-cycle read and byte-over-bit.
      cyc(0, 0, 1, 8'ha8, 8'h05, 8'h00, 3'h0, 0);
      cyc(0, 0, 1, 8'hb8, 8'h01, 8'h00, 3'h0, 0);
      cyc(1, 0, 1, 8'hb8, 8'h00, 8'h7f, 3'h0, 0);
      cyc(1, 0, 1, 8'hb8, 8'h00, 8'h00, 3'h0, 0);
      cyc(0, 1, 1, 8'hb8, 8'h00, 8'h00, 3'h3, 1);
      cyc(0, 1, 1, 8'hb8, 8'h00, 8'h00, 3'h7, 0);
      cyc(1, 0, 1, 8'hb8, 8'h02, 8'h00, 3'h0, 0);
      cyc(1, 1, 1, 8'hb8, 8'h00, 8'h01, 3'h2, 1);
      cyc(0, 1, 1, 8'ha8, 8'h07, 8'h00, 3'h7, 1);
      cyc(0, 0, 1, 8'h55, 8'h00, 8'h00, 3'h0, 0);
      $display("test registers done");
      // Each mask alone, global off, and both Timer 2 flags.
      pend <= 8'h7f;
      for (int i = 0; i < 7; i++) cyc(1, 0, 0, 8'ha8, 8'h03, 8'h80 | (8'h01 << i), 3'h0, 0);
      cyc(1, 0, 0, 8'ha8, 8'h00, 8'h7f, 3'h0, 0);
      cyc(1, 0, 0, 8'ha8, 8'h00, 8'ha0, 3'h0, 0);
      cyc(0, 0, 0, 8'ha8, 8'h00, 8'h00, 3'h0, 0);
      pend <= 8'h80;
      cyc(0, 0, 0, 8'ha8, 8'h00, 8'h00, 3'h0, 0);
      cyc(0, 0, 0, 8'ha8, 8'h00, 8'h00, 3'h0, 0);
      $display("test gating done");
      // Random traffic with nesting, with one reset in the middle.
      for (int n = 0; n < 800; n++) begin
         if (n == 400) begin
            take <= 1'b0;
            retc <= 1'b0;
            do_reset();
         end
         r = $random(seed);
         pend <= r[7:0];
         take <= r[8] | r[9];
         retc <= (r[12:10] == 3'h0);
         cyc(r[15:13] == 0 || r[15:13] == 4, r[15:13] == 2 || r[15:13] == 4,
             r[15:13] == 3 || r[15:13] == 4,
             r[16] ? 8'hb8 : ((r[31] & r[21]) ? 8'h55 : 8'ha8), {7'h00, r[17] & r[18]},
             {r[19] | r[20], r[26:20]}, r[29:27], r[30]);
      end
      $display("test random done");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
